// ---- shared/fault_nvm_pkg.sv ----
// constants, field layouts and state encodings for the fault record and
// user nonvolatile store; assumes a one-byte command code from the front end
package fault_nvm_pkg;

    // ******************************
    // command codes
    // ******************************
    localparam logic [7:0] CMD_USER_NVM_UNLOCK = 8'hBD;
    localparam logic [7:0] CMD_USER_NVM_ERASE = 8'hBE;
    localparam logic [7:0] CMD_USER_NVM_DATA_WORD = 8'hBF;
    localparam logic [7:0] CMD_FAULT_RECORD_WIPE = 8'hE3;

    // ******************************
    // fields and sizes
    // ******************************
    localparam int STATUS_LOG_PRESENT_BIT = 3;
    localparam int LOG_BYTES = 147;
    localparam int LOG_AW = 8;
    localparam logic [7:0] LOG_LAST = 8'h92;
    localparam logic [7:0] LOG_ERASED = 8'h00;
    localparam int NVM_AW = 6;
    localparam int NVM_WORDS = 64;
    localparam logic [5:0] NVM_LAST = 6'h3F;
    localparam logic [15:0] NVM_ERASED = 16'hFFFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ******************************
    // temperature thresholds, whole degrees C
    // ******************************
    localparam int TEMP_W = 10;
    localparam logic signed [9:0] TEMP_HOT_C = 10'sh082;
    localparam logic signed [9:0] TEMP_COOL_C = 10'sh07D;

    // ******************************
    // timing
    // ******************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int WIPE_LIMIT_NS = 8000000;
    // longest time, so round down
    localparam int WIPE_LIMIT_CYC = WIPE_LIMIT_NS / CLK_PERIOD_NS;

    // ******************************
    // states
    // ******************************
    typedef enum logic [1:0] {
        LOG_IDLE = 2'b01,
        LOG_WIPE = 2'b10
    } log_state_e;

    typedef enum logic [1:0] {
        NVM_READY = 2'b01,
        NVM_ERASE = 2'b10
    } nvm_state_e;

endpackage : fault_nvm_pkg

// ---- shared/nvm_if.sv ----
// link between the command logic and the user word store
// assumes both ends share one clock
`timescale 1ns/1ps
interface nvm_if;
    logic rd_req;
    logic wr_req;
    logic erase_req;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic busy;

    modport ctrl (
        output rd_req, wr_req, erase_req, wdata,
        input rdata, rvalid, busy
    );
    modport store (
        input rd_req, wr_req, erase_req, wdata,
        output rdata, rvalid, busy
    );
endinterface : nvm_if

// ---- rtl/nvm_word_store.sv ----
// user nonvolatile word array with a sequential pointer and bulk erase
// assumes requests come only while busy is low
`timescale 1ns/1ps
module nvm_word_store
    import fault_nvm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // command side
    nvm_if.store nv
);

    typedef struct packed {
        nvm_state_e st;
        logic [NVM_AW-1:0] ptr;
        logic [15:0] rdata;
        logic rvalid;
    } store_s;

    store_s cur;
    store_s next_cur;
    logic [15:0] mem [NVM_WORDS];
    logic mem_we;
    logic [15:0] mem_wdata;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        next_cur = cur;
        next_cur.rvalid = 1'b0;
        mem_we = 1'b0;
        mem_wdata = nv.wdata;
        case (cur.st)
            NVM_READY: begin
                if (nv.erase_req) begin
                    next_cur.st = NVM_ERASE;
                    next_cur.ptr = '0;
                end else if (nv.wr_req) begin
                    mem_we = 1'b1;
                    next_cur.ptr = cur.ptr + 6'h01;
                end else if (nv.rd_req) begin
                    next_cur.rdata = mem[cur.ptr];
                    next_cur.rvalid = 1'b1;
                    next_cur.ptr = cur.ptr + 6'h01;
                end
            end
            NVM_ERASE: begin
                mem_we = 1'b1;
                mem_wdata = NVM_ERASED;
                next_cur.ptr = cur.ptr + 6'h01;
                if (cur.ptr == NVM_LAST) begin
                    next_cur.st = NVM_READY;
                end
            end
            default: begin
                next_cur.st = NVM_READY;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '{st: NVM_READY, ptr: '0, rdata: '0, rvalid: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // array has no reset; it models stored contents
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[cur.ptr] <= mem_wdata;
        end
    end

    assign nv.rdata = cur.rdata;
    assign nv.rvalid = cur.rvalid;
    assign nv.busy = (cur.st == NVM_ERASE);

    // ******************************
    // checks
    // ******************************
    AST_PTR_STEP: assert property (
        @(posedge clk) disable iff (!nrst)
        (cur.st == NVM_READY && (nv.wr_req || nv.rd_req) && !nv.erase_req)
        |=> cur.ptr == $past(cur.ptr) + 6'h01)
        else $error("word pointer did not advance");

    AST_ERASE_FILL: assert property (
        @(posedge clk) disable iff (!nrst)
        (cur.st == NVM_READY && nv.erase_req)
        |=> nv.busy [*8] ##56 nv.busy ##1 (!nv.busy && cur.ptr == '0))
        else $error("erase walk length wrong");

endmodule : nvm_word_store

// ---- rtl/fault_log_nvm_ctrl.sv ----
// command logic for the fault record and user nonvolatile memory
// assumes the bus front end hands over one decoded command per pulse
`timescale 1ns/1ps

module fault_log_nvm_ctrl
    import fault_nvm_pkg::*;
#(
    parameter int WIPE_LIMIT = WIPE_LIMIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // decoded commands
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_send_byte,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_data,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic cmd_err,
    // die temperature, whole degrees C
    input wire logic signed [TEMP_W-1:0] die_temp,
    output logic nvm_hot,
    // fault record
    input wire logic log_we,
    input wire logic [LOG_AW-1:0] log_waddr,
    input wire logic [7:0] log_wdata,
    input wire logic log_present_set,
    input wire logic [LOG_AW-1:0] log_raddr,
    output logic [7:0] log_rdata,
    output logic wipe_busy,
    // status byte
    input wire logic [7:0] vendor_status_in,
    output logic [7:0] vendor_status_byte
);

    localparam int WIPE_LEN = 147;

    typedef struct packed {
        log_state_e st;
        logic [LOG_AW-1:0] wipe_addr;
        logic log_present;
        logic unlocked;
        logic hot;
        logic rd_wait;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic cmd_err;
        logic [7:0] vstat;
    } ctrl_s;

    ctrl_s cur;
    ctrl_s next_cur;
    logic [7:0] log_mem [LOG_BYTES];
    logic nvm_cmd;
    logic gated_ok;
    logic wipe_ok;
    int wipe_age;

    nvm_if nv ();

    nvm_word_store nvm_word_store_inst (
        .clk(clk),
        .nrst(nrst),
        .nv(nv.store)
    );

    // ******************************
    // decode
    // ******************************
    assign nvm_cmd = cmd_valid && (cmd_code == CMD_USER_NVM_ERASE
        || cmd_code == CMD_USER_NVM_DATA_WORD);
    // the front end is page-aware; these codes ignore the page
    assign gated_ok = !cur.hot && cur.unlocked && !nv.busy
        && !cur.rd_wait;
    assign wipe_ok = cmd_write && cmd_send_byte;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        next_cur = cur;
        next_cur.rsp_valid = 1'b0;
        next_cur.cmd_err = 1'b0;
        nv.rd_req = 1'b0;
        nv.wr_req = 1'b0;
        nv.erase_req = 1'b0;
        nv.wdata = cmd_data;
        // hysteresis so a die near the limit does not chatter
        if (cur.hot) begin
            next_cur.hot = !(die_temp < TEMP_COOL_C);
        end else begin
            next_cur.hot = die_temp > TEMP_HOT_C;
        end
        if (cur.rd_wait && nv.rvalid) begin
            next_cur.rd_wait = 1'b0;
            next_cur.rsp_valid = 1'b1;
            next_cur.rsp_data = nv.rdata;
        end
        case (cur.st)
            LOG_IDLE: begin
            end
            LOG_WIPE: begin
                next_cur.wipe_addr = cur.wipe_addr + 8'h01;
                if (cur.wipe_addr == LOG_LAST) begin
                    next_cur.st = LOG_IDLE;
                    next_cur.log_present = 1'b0;
                end
            end
            default: begin
                next_cur.st = LOG_IDLE;
            end
        endcase
        // a new log arriving as the wipe ends must not be lost
        if (log_present_set) begin
            next_cur.log_present = 1'b1;
        end
        if (cmd_valid) begin
            case (cmd_code)
                CMD_FAULT_RECORD_WIPE: begin
                    if (wipe_ok) begin
                        next_cur.st = LOG_WIPE;
                        next_cur.wipe_addr = '0;
                    end else begin
                        next_cur.cmd_err = 1'b1;
                    end
                end
                CMD_USER_NVM_UNLOCK: begin
                    if (cur.hot || (cmd_write && cmd_send_byte)) begin
                        next_cur.cmd_err = 1'b1;
                    end else if (cmd_write) begin
                        next_cur.unlocked = 1'b1;
                    end else begin
                        next_cur.rsp_valid = 1'b1;
                        next_cur.rsp_data = {15'h0000, cur.unlocked};
                    end
                end
                CMD_USER_NVM_ERASE: begin
                    if (!gated_ok || (cmd_write && cmd_send_byte)) begin
                        next_cur.cmd_err = 1'b1;
                    end else if (cmd_write) begin
                        nv.erase_req = 1'b1;
                    end else begin
                        next_cur.rsp_valid = 1'b1;
                        next_cur.rsp_data = 16'h0000;
                    end
                end
                CMD_USER_NVM_DATA_WORD: begin
                    if (!gated_ok || (cmd_write && cmd_send_byte)) begin
                        next_cur.cmd_err = 1'b1;
                    end else if (cmd_write) begin
                        nv.wr_req = 1'b1;
                    end else begin
                        nv.rd_req = 1'b1;
                        next_cur.rd_wait = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        next_cur.vstat = vendor_status_in;
        next_cur.vstat[STATUS_LOG_PRESENT_BIT] = next_cur.log_present;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '{st: LOG_IDLE, wipe_addr: '0, log_present: 1'b0,
                unlocked: 1'b0, hot: 1'b0, rd_wait: 1'b0, rsp_valid: 1'b0,
                rsp_data: '0, cmd_err: 1'b0, vstat: STATUS_RESET};
        end else begin
            cur <= next_cur;
        end
    end

    // ******************************
    // fault record array
    // ******************************
    // logger writes are dropped during a wipe so the record ends empty
    always_ff @(posedge clk) begin
        if (cur.st == LOG_WIPE) begin
            log_mem[cur.wipe_addr] <= LOG_ERASED;
        end else if (log_we && log_waddr <= LOG_LAST) begin
            log_mem[log_waddr] <= log_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            log_rdata <= 8'h00;
        end else if (log_raddr <= LOG_LAST) begin
            log_rdata <= log_mem[log_raddr];
        end else begin
            log_rdata <= 8'h00;
        end
    end

    assign rsp_valid = cur.rsp_valid;
    assign rsp_data = cur.rsp_data;
    assign cmd_err = cur.cmd_err;
    assign nvm_hot = cur.hot;
    assign wipe_busy = (cur.st == LOG_WIPE);
    assign vendor_status_byte = cur.vstat;

    // ******************************
    // checks
    // ******************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wipe_age <= 0;
        end else if (cur.st == LOG_WIPE) begin
            wipe_age <= wipe_age + 1;
        end else begin
            wipe_age <= 0;
        end
    end

    sequence wipe_start_s;
        cmd_valid && cmd_code == CMD_FAULT_RECORD_WIPE && wipe_ok;
    endsequence

    // the walk is too long to unroll; the age counter proves it unbroken
    sequence wipe_walk_s;
        wipe_busy ##146 (wipe_busy && wipe_age == WIPE_LEN - 1)
        ##1 !wipe_busy;
    endsequence

    AST_WIPE_WALK: assert property (
        @(posedge clk) disable iff (!nrst)
        wipe_start_s |=> wipe_walk_s)
        else $error("wipe walk length wrong");

    AST_WIPE_ZERO: assert property (
        @(posedge clk) disable iff (!nrst)
        wipe_busy |=> log_mem[$past(cur.wipe_addr)] == LOG_ERASED)
        else $error("wiped byte not erased");

    AST_STATUS_CLEAR: assert property (
        @(posedge clk) disable iff (!nrst)
        (wipe_busy && cur.wipe_addr == LOG_LAST && !log_present_set)
        |=> !vendor_status_byte[STATUS_LOG_PRESENT_BIT])
        else $error("log present bit not cleared");

    AST_WIPE_TIME: assert property (
        @(posedge clk) disable iff (!nrst)
        wipe_age < WIPE_LIMIT)
        else $error("wipe took too long");

    AST_LOCKED_REFUSE: assert property (
        @(posedge clk) disable iff (!nrst)
        (nvm_cmd && !cur.unlocked)
        |-> !nv.erase_req && !nv.wr_req && !nv.rd_req ##1 cmd_err)
        else $error("locked command not refused");

    AST_HOT_SET: assert property (
        @(posedge clk) disable iff (!nrst)
        die_temp > TEMP_HOT_C |=> nvm_hot)
        else $error("over temperature not seen");

    AST_HOT_HOLD: assert property (
        @(posedge clk) disable iff (!nrst)
        (nvm_hot && die_temp >= TEMP_COOL_C) |=> nvm_hot)
        else $error("hysteresis released early");

    AST_HOT_REFUSE: assert property (
        @(posedge clk) disable iff (!nrst)
        (nvm_cmd && cur.hot) |=> cmd_err && !rsp_valid)
        else $error("hot command not flagged");

    AST_READ_ANSWER: assert property (
        @(posedge clk) disable iff (!nrst)
        nv.rd_req |-> ##2 rsp_valid)
        else $error("data read not answered");

endmodule : fault_log_nvm_ctrl

// ---- tb/host_cmd_model.sv ----
// management bus host that presents decoded commands to the block
// assumes the block takes a command at the rising edge with valid high
`timescale 1ns/1ps
module host_cmd_model (
    // clock
    input wire logic clk,
    // command lines
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_send_byte,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_send_byte = 1'b0;
        cmd_code = 8'h00;
        cmd_data = 16'h0000;
    end

    // ******************************
    // one command, optionally after idle cycles (slow host)
    // ******************************
    task automatic issue(input logic w, input logic sb, input logic [7:0] c,
                         input logic [15:0] d, input int idle);
        repeat (idle) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_send_byte = sb;
        cmd_code = c;
        // a send-byte carries no data, so the data lines hold junk
        cmd_data = sb ? ~cmd_data : d;
        @(posedge clk);
        @(negedge clk);
        // released code and data lines show the inverse so stale values never pass
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_data = ~cmd_data;
    endtask : issue
endmodule : host_cmd_model

// ---- tb/fault_log_and_user_nvm_access_tb.sv ----
// self-checking bench for the fault record and user memory commands
// assumes the host model drives the command port on falling edges
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_mismatch++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module fault_log_and_user_nvm_access_tb
    import fault_nvm_pkg::*;
;
    typedef struct packed {
        logic w;
        logic sb;
        logic [7:0] code;
        logic [15:0] data;
        logic err;
        logic rv;
        logic [15:0] rd;
        logic [7:0] gap;
    } row_s;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid, cmd_write, cmd_send_byte;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data, rsp_data;
    logic rsp_valid, cmd_err, nvm_hot, wipe_busy;
    logic signed [TEMP_W-1:0] die_temp = 10'h019;
    logic log_we = 1'b0;
    logic log_present_set = 1'b0;
    logic [LOG_AW-1:0] log_waddr = 8'h00;
    logic [LOG_AW-1:0] log_raddr = 8'h00;
    logic [7:0] log_wdata = 8'h00;
    logic [7:0] log_rdata, vendor_status_byte;
    logic [7:0] vendor_status_in = 8'hA4;
    int n_mismatch = 0;
    int n_tests = 0;
    logic e, v;
    logic [15:0] d;
    int cnt;

    // locked first, then unlocked; the erase row waits out the erase
    row_s rows [12] = '{
        '{1'b0, 1'b0, 8'hBE, 16'h0000, 1'b1, 1'b0, 16'h0000, 8'h00},
        '{1'b1, 1'b0, 8'hBF, 16'h1234, 1'b1, 1'b0, 16'h0000, 8'h00},
        '{1'b0, 1'b0, 8'hBD, 16'h0000, 1'b0, 1'b1, 16'h0000, 8'h00},
        '{1'b1, 1'b0, 8'hBD, 16'h0001, 1'b0, 1'b0, 16'h0000, 8'h00},
        '{1'b0, 1'b0, 8'hBD, 16'h0000, 1'b0, 1'b1, 16'h0001, 8'h00},
        '{1'b1, 1'b1, 8'hBD, 16'h0000, 1'b1, 1'b0, 16'h0000, 8'h00},
        '{1'b0, 1'b0, 8'hBE, 16'h0000, 1'b0, 1'b1, 16'h0000, 8'h00},
        '{1'b1, 1'b0, 8'hBE, 16'h0000, 1'b0, 1'b0, 16'h0000, 8'h40},
        '{1'b0, 1'b0, 8'hBF, 16'h0000, 1'b0, 1'b1, 16'hFFFF, 8'h00},
        '{1'b1, 1'b0, 8'hE3, 16'h0000, 1'b1, 1'b0, 16'h0000, 8'h00},
        '{1'b0, 1'b0, 8'hE3, 16'h0000, 1'b1, 1'b0, 16'h0000, 8'h00},
        '{1'b1, 1'b0, 8'h55, 16'h0000, 1'b0, 1'b0, 16'h0000, 8'h00}
    };

    always #4 clk = ~clk;

    host_cmd_model host_cmd_model_inst (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_send_byte(cmd_send_byte), .cmd_code(cmd_code),
        .cmd_data(cmd_data)
    );

    // wipe bound shortened; the wipe itself still walks all bytes
    fault_log_nvm_ctrl #(.WIPE_LIMIT(200)) fault_log_nvm_ctrl_inst (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_send_byte(cmd_send_byte),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .cmd_err(cmd_err), .die_temp(die_temp),
        .nvm_hot(nvm_hot), .log_we(log_we), .log_waddr(log_waddr),
        .log_wdata(log_wdata), .log_present_set(log_present_set),
        .log_raddr(log_raddr), .log_rdata(log_rdata),
        .wipe_busy(wipe_busy), .vendor_status_in(vendor_status_in),
        .vendor_status_byte(vendor_status_byte)
    );

    // ******************************
    // helpers
    // ******************************
    // samples now and on the next falling edges, so a pulse is not missed
    task automatic watch(input int n, output logic err, output logic rv,
                         output logic [15:0] rd);
        err = 1'b0;
        rv = 1'b0;
        rd = 16'hXXXX;
        repeat (n) begin
            err = err | cmd_err;
            if (rsp_valid === 1'b1) begin
                rv = 1'b1;
                rd = rsp_data;
            end
            @(negedge clk);
        end
    endtask : watch

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ******************************
    // main sequence
    // ******************************
    initial begin
        repeat (10) @(negedge clk);
        `CHK("rst_status", 8'h00, vendor_status_byte)
        `CHK("rst_busy", 1'b0, wipe_busy)
        nrst = 1'b1;
        foreach (rows[i]) begin
            host_cmd_model_inst.issue(rows[i].w, rows[i].sb, rows[i].code,
                                      rows[i].data, i % 2);
            watch(3, e, v, d);
            `CHK("err", rows[i].err, e)
            `CHK("rsp", rows[i].rv, v)
            if (rows[i].rv) `CHK("rdata", rows[i].rd, d)
            repeat (rows[i].gap) @(negedge clk);
        end
        // pointer sits at 1; 64 writes wrap it back to 1
        for (int i = 0; i < NVM_WORDS; i++)
            host_cmd_model_inst.issue(1'b1, 1'b0, 8'hBF, 16'hA500 + 16'(i), 0);
        for (int i = 0; i < NVM_WORDS; i++) begin
            host_cmd_model_inst.issue(1'b0, 1'b0, 8'hBF, 16'h0000, 0);
            watch(3, e, v, d);
            `CHK("word", 16'hA500 + 16'(i), d)
        end
        // hysteresis: rows of 130, 131, 127, 125, 124 degrees
        foreach (rows[i]) begin
            if (i < 5) begin
                die_temp = (i == 0) ? 10'h082 : (i == 1) ? 10'h083 :
                           (i == 2) ? 10'h07F : (i == 3) ? 10'h07D : 10'h07C;
                @(negedge clk);
                `CHK("hot", (i > 0 && i < 4), nvm_hot)
                host_cmd_model_inst.issue(1'b0, 1'b0, 8'hBF, 16'h0000, 0);
                watch(3, e, v, d);
                `CHK("hot_err", (i > 0 && i < 4), e)
            end
        end
        for (int i = 0; i < LOG_BYTES; i++) begin
            @(negedge clk);
            log_we = 1'b1;
            log_waddr = 8'(i);
            log_wdata = 8'h5A;
        end
        @(negedge clk);
        log_we = 1'b0;
        log_present_set = 1'b1;
        @(negedge clk);
        log_present_set = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("status_set", 8'hAC, vendor_status_byte)
        host_cmd_model_inst.issue(1'b1, 1'b1, 8'hE3, 16'h0000, 0);
        cnt = 0;
        repeat (200) begin
            cnt += int'(wipe_busy === 1'b1);
            @(negedge clk);
        end
        `CHK("wipe_cycles", 147, cnt)
        `CHK("status_clr", 8'hA4, vendor_status_byte)
        for (int i = 0; i < LOG_BYTES; i++) begin
            log_raddr = 8'(i);
            @(negedge clk);
            `CHK("log_byte", 8'h00, log_rdata)
        end
        // a data read during an erase is refused; the pointer restarts at 0
        host_cmd_model_inst.issue(1'b1, 1'b0, 8'hBE, 16'h0000, 0);
        host_cmd_model_inst.issue(1'b0, 1'b0, 8'hBF, 16'h0000, 0);
        watch(3, e, v, d);
        `CHK("busy_err", 1'b1, e)
        `CHK("busy_rsp", 1'b0, v)
        repeat (64) @(negedge clk);
        host_cmd_model_inst.issue(1'b0, 1'b0, 8'hBF, 16'h0000, 0);
        watch(3, e, v, d);
        `CHK("erased", 16'hFFFF, d)
        // a second reset must lock the memory again
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("rst2_status", 8'h00, vendor_status_byte)
        nrst = 1'b1;
        host_cmd_model_inst.issue(1'b0, 1'b0, 8'hBE, 16'h0000, 0);
        watch(3, e, v, d);
        `CHK("relock", 1'b1, e)
        tally_and_finish();
    end
endmodule : fault_log_and_user_nvm_access_tb
